// ==== shared/dxbps_defs.svh ====
// Constants for the slave broadcast exchange publisher/subscriber ends
`ifndef DXBPS_DEFS_SVH
`define DXBPS_DEFS_SVH

// ----------------------------------------------------------------------
// Link sizing and telegram constants
// ----------------------------------------------------------------------
`define DXBPS_MAX_LINKS 29
`define DXBPS_FC_MULTICAST 4'h7
`define DXBPS_BCAST_ADDR 7'h7f
`define DXBPS_PRM_LAST_BYTE 7'h78
`define DXBPS_TYPE_LINK_TAB 8'h03
`define DXBPS_TYPE_SUB_TAB 8'h07
`define DXBPS_TAB_VERSION 8'h01
`define DXBPS_STS_TYPE 8'h83

// ----------------------------------------------------------------------
// Link status byte fields and status message layout
// ----------------------------------------------------------------------
`define DXBPS_LS_ACTIVE 7
`define DXBPS_LS_FAULT 6
`define DXBPS_LS_FRESH 0
`define DXBPS_HDR_LEN_W 6
`define DXBPS_STS_FIRST_LINK 5
`define DXBPS_PUB_EN_BIT 0

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DXBPS_REG_EXT_STS 10'h000
`define DXBPS_REG_CTRL 10'h004
`define DXBPS_REG_WD_INT 10'h008
`define DXBPS_REG_LTAB_LEN 10'h00c
`define DXBPS_REG_STATE_LEN 10'h010
`define DXBPS_REG_PUB_LEN 10'h014
`define DXBPS_REG_IRQ_STS 10'h018
`define DXBPS_REG_IRQ_MSK 10'h01c
`define DXBPS_REG_PRM 10'h020
`define DXBPS_LTAB_BASE 10'h100
`define DXBPS_SBUF_BASE 10'h200

// ----------------------------------------------------------------------
// Control and interrupt bits, reset values
// ----------------------------------------------------------------------
`define DXBPS_CTRL_DEXCH 0
`define DXBPS_CTRL_WD_EN 1
`define DXBPS_IRQ_FRESH 0
`define DXBPS_IRQ_FAULT 1
`define DXBPS_IRQ_PUB 2
`define DXBPS_IRQ_WD 3
`define DXBPS_IRQ_PRM 4
`define DXBPS_WD_INT_RST 20'h0c350
`define DXBPS_RESP_OKAY 2'b00
`define DXBPS_RESP_SLVERR 2'b10

`endif

// ==== shared/dxbps_pkg.sv ====
// Types shared by both ends of the broadcast exchange link
package dxbps_pkg;
  `include "dxbps_defs.svh"

  // Telegram kinds delivered to the device
  typedef enum logic [1:0] {
    DXBPS_TK_FC7,
    DXBPS_TK_BCAST,
    DXBPS_TK_PRM,
    DXBPS_TK_OTHER
  } dxbps_kind_t;

  // Complete state of the device end
  typedef struct packed {
    logic [7:0] ext_sts;
    logic [1:0] ctrl;
    logic [19:0] wd_int;
    logic [19:0] wd_cnt;
    logic [4:0] ltab_len;
    logic [5:0] state_len;
    logic [7:0] pub_len;
    logic [4:0] irq_sts;
    logic [4:0] irq_msk;
    logic [28:0][31:0] ltab;
    logic [63:0][7:0] sbuf;
    logic [7:0] prm_byte;
    logic prm_full;
    logic aw_ok;
    logic [9:0] aw_a;
    logic w_ok;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rsp_valid;
    logic [7:0] rsp_len;
  } dxbps_dev_t;

  // Complete state of the bus-side end
  typedef struct packed {
    logic tv;
    dxbps_kind_t kind;
    logic [6:0] src;
    logic [6:0] dest;
    logic [7:0] len;
    logic [7:0] data;
    logic err;
    logic [6:0] pcnt;
    logic rep_stb;
    logic [6:0] rep_dest;
    logic [7:0] rep_len;
  } dxbps_bus_t;
endpackage

// ==== shared/dxbps_link_if.sv ====
// Telegram-level link between the device end and the bus-side end
`timescale 1ns/1ps
interface dxbps_link_if;
  import dxbps_pkg::*;
  logic tel_valid;
  logic tel_ready;
  dxbps_kind_t tel_kind;
  logic [6:0] tel_src;
  logic [6:0] tel_dest;
  logic [7:0] tel_len;
  logic [7:0] tel_data;
  logic tel_err;
  logic rsp_valid;
  logic rsp_ready;
  logic [6:0] rsp_dest;
  logic [7:0] rsp_len;

  modport dev (
    input tel_valid, tel_kind, tel_src, tel_dest, tel_len, tel_data, tel_err, rsp_ready,
    output tel_ready, rsp_valid, rsp_dest, rsp_len
  );
  modport bus (
    output tel_valid, tel_kind, tel_src, tel_dest, tel_len, tel_data, tel_err, rsp_ready,
    input tel_ready, rsp_valid, rsp_dest, rsp_len
  );
endinterface

// ==== rtl/dxbps_bus_end.sv ====
// Bus-side end: turns user commands into telegrams, collects replies
`timescale 1ns/1ps
`include "dxbps_defs.svh"
module dxbps_bus_end
  import dxbps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  dxbps_link_if.bus link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire dxbps_kind_t cmd_kind,
  input wire logic [6:0] cmd_src,
  input wire logic [6:0] cmd_dest,
  input wire logic [7:0] cmd_len,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_err,
  input wire logic cmd_last,
  output logic rep_stb,
  output logic [6:0] rep_dest,
  output logic [7:0] rep_len
);
  dxbps_bus_t q, n;
  logic prm_room;

  // ----------------------------------------------------------------------
  // Command side
  // ----------------------------------------------------------------------
  // A parameter block may not run past its last byte index
  assign prm_room = (cmd_kind != DXBPS_TK_PRM) || (q.pcnt <= `DXBPS_PRM_LAST_BYTE); // [RL8] [RL9]
  assign cmd_ready = !q.tv && prm_room;
  assign link.tel_valid = q.tv;
  assign link.tel_kind = q.kind;
  assign link.tel_src = q.src;
  assign link.tel_dest = q.dest;
  assign link.tel_len = q.len;
  assign link.tel_data = q.data;
  assign link.tel_err = q.err;
  // Replies are short single words, so they are always taken at once
  assign link.rsp_ready = 1'b1;
  assign rep_stb = q.rep_stb;
  assign rep_dest = q.rep_dest;
  assign rep_len = q.rep_len;

  // Next state: hold each telegram until the device takes it
  always_comb begin
    n = q;
    n.rep_stb = 1'b0;
    if (q.tv && link.tel_ready) begin
      n.tv = 1'b0;
    end
    if (cmd_valid && cmd_ready) begin
      n.tv = 1'b1;
      n.kind = cmd_kind;
      n.src = cmd_src;
      n.dest = cmd_dest;
      n.len = cmd_len;
      n.data = cmd_data;
      n.err = cmd_err;
      if (cmd_kind == DXBPS_TK_PRM) begin
        n.pcnt = cmd_last ? 7'h00 : q.pcnt + 7'h01; // [RL8] [RL9]
      end
    end
    if (link.rsp_valid) begin
      n.rep_stb = 1'b1;
      n.rep_dest = link.rsp_dest;
      n.rep_len = link.rsp_len;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule

// ==== rtl/dxbps_dev_end.sv ====
// Device end: publisher reply, subscriber link monitor and register file
//
// Behaviour
// RL1: monitor up to 29 publisher links together
// RL2: publish only while publisher enable bit set
// RL3: answer code 7 requests towards address 127
// RL4: drop code 7 requests when publishing disabled
// RL5: accept broadcasts only from listed publishers
// RL6: publisher reply goes out as broadcast
// RL7: parameter block bytes reach firmware unchanged
// RL8: link table block layout, entries to 120
// RL9: subscriber table type 7, six-byte entries
// RL10: firmware loads link buffer and length setting
// RL11: firmware writes default status before acknowledging
// RL12: bit 7 shows link active last period
// RL13: bit 6 flags faulty broadcast reception
// RL14: bit 0 flags fresh error-free reception
// RL15: firmware ensures the watchdog is enabled
// RL16: status message header, then address/status pairs
// RL17: each listed reception updates its status byte
// RL18: watchdog expiry rolls fresh into active, restarts
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dxbps_defs.svh"
module dxbps_dev_end
  import dxbps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  dxbps_link_if.dev link,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  dxbps_dev_t q, n;

  // ----------------------------------------------------------------------
  // Address decoding helpers
  // ----------------------------------------------------------------------
  // Link table window, one word per link
  function automatic logic is_ltab(input logic [9:0] a);
    is_ltab = (a[9:7] == `DXBPS_LTAB_BASE >> 7) && (a[6:2] < 5'(`DXBPS_MAX_LINKS));
  endfunction

  // Status message window, sixteen words
  function automatic logic is_sbuf(input logic [9:0] a);
    is_sbuf = (a[9:6] == `DXBPS_SBUF_BASE >> 6);
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        merge[8*b +: 8] = d[8*b +: 8];
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // Handshakes and outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = !q.aw_ok;
  assign s_axi_wready = !q.w_ok;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  // A pending reply or an unread parameter byte stalls the link
  assign link.tel_ready = !q.rsp_valid && !q.prm_full;
  assign link.rsp_valid = q.rsp_valid;
  assign link.rsp_dest = `DXBPS_BCAST_ADDR; // [RL3] [RL6]
  assign link.rsp_len = q.rsp_len;
  assign irq = |(q.irq_sts & q.irq_msk);

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Bus accesses first, then link events, so hardware updates win
  always_comb begin
    logic [4:0] ev;
    logic rd_clr;
    logic [31:0] m;
    logic take;
    logic hit;
    logic [4:0] hi;
    logic [5:0] j;
    logic bad;
    n = q;
    ev = '0;
    rd_clr = 1'b0;
    m = '0;
    take = link.tel_valid && link.tel_ready;
    hit = 1'b0;
    hi = '0;
    j = '0;
    bad = 1'b0;

    // Write address and data are captured in either order
    if (s_axi_awvalid && !q.aw_ok) begin
      n.aw_ok = 1'b1;
      n.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_ok) begin
      n.w_ok = 1'b1;
      n.w_d = s_axi_wdata;
      n.w_s = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (q.aw_ok && q.w_ok && !q.bvalid) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `DXBPS_RESP_OKAY;
      unique case ({q.aw_a[9:2], 2'b00})
        `DXBPS_REG_EXT_STS: n.ext_sts = 8'(merge({24'h0, q.ext_sts}, q.w_d, q.w_s));
        `DXBPS_REG_CTRL: n.ctrl = 2'(merge({30'h0, q.ctrl}, q.w_d, q.w_s));
        `DXBPS_REG_WD_INT: n.wd_int = 20'(merge({12'h0, q.wd_int}, q.w_d, q.w_s));
        `DXBPS_REG_LTAB_LEN: n.ltab_len = 5'(merge({27'h0, q.ltab_len}, q.w_d, q.w_s)); // [RL10]
        `DXBPS_REG_STATE_LEN: n.state_len = 6'(merge({26'h0, q.state_len}, q.w_d, q.w_s));
        `DXBPS_REG_PUB_LEN: n.pub_len = 8'(merge({24'h0, q.pub_len}, q.w_d, q.w_s));
        `DXBPS_REG_IRQ_MSK: n.irq_msk = 5'(merge({27'h0, q.irq_msk}, q.w_d, q.w_s));
        `DXBPS_REG_IRQ_STS, `DXBPS_REG_PRM: ;
        default: begin
          if (is_ltab(q.aw_a)) begin
            n.ltab[q.aw_a[6:2]] = merge(q.ltab[q.aw_a[6:2]], q.w_d, q.w_s); // [RL10]
          end else if (is_sbuf(q.aw_a)) begin
            // Firmware lays down the default status message here
            for (int b = 0; b < 4; b++) begin
              if (q.w_s[b]) begin
                n.sbuf[{q.aw_a[5:2], 2'(b)}] = q.w_d[8*b +: 8]; // [RL11] [RL16]
              end
            end
          end else begin
            n.bresp = `DXBPS_RESP_SLVERR;
          end
        end
      endcase
    end

    // Reads answer one cycle after the address is taken
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = `DXBPS_RESP_OKAY;
      unique case ({s_axi_araddr[9:2], 2'b00})
        `DXBPS_REG_EXT_STS: m = {24'h0, q.ext_sts};
        `DXBPS_REG_CTRL: m = {30'h0, q.ctrl};
        `DXBPS_REG_WD_INT: m = {12'h0, q.wd_int};
        `DXBPS_REG_LTAB_LEN: m = {27'h0, q.ltab_len};
        `DXBPS_REG_STATE_LEN: m = {26'h0, q.state_len};
        `DXBPS_REG_PUB_LEN: m = {24'h0, q.pub_len};
        `DXBPS_REG_IRQ_STS: begin
          m = {27'h0, q.irq_sts};
          rd_clr = 1'b1;
        end
        `DXBPS_REG_IRQ_MSK: m = {27'h0, q.irq_msk};
        `DXBPS_REG_PRM: begin
          // Popping frees the holding byte for the next one
          m = {23'h0, q.prm_full, q.prm_byte}; // [RL7]
          n.prm_full = 1'b0;
        end
        default: begin
          if (is_ltab(s_axi_araddr)) begin
            m = q.ltab[s_axi_araddr[6:2]];
          end else if (is_sbuf(s_axi_araddr)) begin
            m = {q.sbuf[{s_axi_araddr[5:2], 2'd3}], q.sbuf[{s_axi_araddr[5:2], 2'd2}],
                 q.sbuf[{s_axi_araddr[5:2], 2'd1}], q.sbuf[{s_axi_araddr[5:2], 2'd0}]};
          end else begin
            n.rresp = `DXBPS_RESP_SLVERR;
          end
        end
      endcase
      n.rdata = m;
    end

    // Monitoring interval runs only in data exchange with watchdog on
    if (!(q.ctrl[`DXBPS_CTRL_DEXCH] && q.ctrl[`DXBPS_CTRL_WD_EN])) begin // [RL15]
      n.wd_cnt = '0;
    end else if (q.wd_cnt >= q.wd_int) begin
      n.wd_cnt = '0; // [RL18]
      ev[`DXBPS_IRQ_WD] = 1'b1;
      for (int i = 0; i < `DXBPS_MAX_LINKS; i++) begin
        j = 6'(`DXBPS_STS_FIRST_LINK + 2 * i);
        if (5'(i) < q.ltab_len && j < q.state_len) begin
          n.sbuf[j][`DXBPS_LS_ACTIVE] = n.sbuf[j][`DXBPS_LS_FRESH]; // [RL12] [RL18]
          n.sbuf[j][`DXBPS_LS_FAULT] = 1'b0; // [RL18]
          n.sbuf[j][`DXBPS_LS_FRESH] = 1'b0; // [RL18]
        end
      end
    end else begin
      n.wd_cnt = q.wd_cnt + 20'h1;
    end

    // Publisher: code 7 request gets a broadcast reply, or is dropped
    if (take && link.tel_kind == DXBPS_TK_FC7 && link.tel_len[3:0] == `DXBPS_FC_MULTICAST) begin
      if (q.ext_sts[`DXBPS_PUB_EN_BIT]) begin // [RL2] [RL4]
        n.rsp_valid = 1'b1; // [RL3] [RL6]
        n.rsp_len = q.pub_len;
        ev[`DXBPS_IRQ_PUB] = 1'b1;
      end
    end
    if (q.rsp_valid && link.rsp_ready) begin
      n.rsp_valid = 1'b0;
    end

    // Subscriber: first listed link whose publisher matches the source
    if (take && link.tel_kind == DXBPS_TK_BCAST && link.tel_dest == `DXBPS_BCAST_ADDR) begin
      for (int i = 0; i < `DXBPS_MAX_LINKS; i++) begin // [RL1]
        if (!hit && 5'(i) < q.ltab_len && q.ltab[i][7:0] == {1'b0, link.tel_src}) begin // [RL5]
          hit = 1'b1;
          hi = 5'(i);
        end
      end
      bad = link.tel_err || (link.tel_len != q.ltab[hi][15:8]);
      j = 6'(`DXBPS_STS_FIRST_LINK + 2 * hi);
      if (hit && j < q.state_len) begin // [RL17]
        if (bad) begin
          n.sbuf[j][`DXBPS_LS_ACTIVE] = 1'b0;
          n.sbuf[j][`DXBPS_LS_FAULT] = 1'b1; // [RL13]
          n.sbuf[j][`DXBPS_LS_FRESH] = 1'b0;
          ev[`DXBPS_IRQ_FAULT] = 1'b1;
        end else begin
          n.sbuf[j][`DXBPS_LS_FAULT] = 1'b0;
          n.sbuf[j][`DXBPS_LS_FRESH] = 1'b1; // [RL14]
          ev[`DXBPS_IRQ_FRESH] = 1'b1;
        end
      end
    end

    // Parameter bytes are held verbatim for firmware to read
    if (take && link.tel_kind == DXBPS_TK_PRM) begin
      n.prm_byte = link.tel_data; // [RL7]
      n.prm_full = 1'b1;
      ev[`DXBPS_IRQ_PRM] = 1'b1;
    end

    // New events win over a clearing read in the same cycle
    n.irq_sts = (rd_clr ? 5'h00 : q.irq_sts) | ev;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.wd_int <= `DXBPS_WD_INT_RST;
    end else begin
      q <= n;
    end
  end
endmodule

// ==== tb/dxbps_link_properties.sv ====
// Concurrent checks on the telegram link between the two ends
`timescale 1ns/1ps
module dxbps_link_properties
  import dxbps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tel_valid,
  input wire logic tel_ready,
  input wire dxbps_kind_t tel_kind,
  input wire logic [7:0] tel_len,
  input wire logic [7:0] tel_data,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [6:0] rsp_dest
);
  // ----------------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A telegram changes hands in this cycle
  sequence take_s;
    tel_valid && tel_ready;
  endsequence
  sequence fc7_bad_s;
    take_s ##0 (tel_kind == DXBPS_TK_FC7 && tel_len[3:0] != 4'h7);
  endsequence
  reply_dest_a: assert property (rsp_valid |-> rsp_dest == 7'h7f)
    else $error("reply not sent to broadcast address");
  reply_cause_a: assert property ($rose(rsp_valid) |->
    $past(tel_valid && tel_ready && tel_kind == DXBPS_TK_FC7 && tel_len[3:0] == 4'h7))
    else $error("reply without a code 7 request");
  no_reply_a: assert property (take_s ##0 tel_kind != DXBPS_TK_FC7 |=> !rsp_valid)
    else $error("reply to a non request telegram");
  bad_code_a: assert property (fc7_bad_s |=> !rsp_valid)
    else $error("reply to a wrong function code");
  reply_pulse_a: assert property (rsp_valid && rsp_ready |=> !rsp_valid)
    else $error("reply held after hand over");
  busy_refuse_a: assert property (rsp_valid |-> !tel_ready)
    else $error("telegram accepted while reply pending");
  prm_hold_a: assert property (take_s ##0 tel_kind == DXBPS_TK_PRM |=> !tel_ready)
    else $error("parameter byte overwritten before read");
  tel_hold_a: assert property (tel_valid && !tel_ready |=>
    tel_valid && $stable(tel_data) && $stable(tel_kind))
    else $error("telegram changed while waiting");
endmodule

// ==== tb/tb_top.sv ====
// Testbench joining both ends of the broadcast exchange link
`timescale 1ns/1ps
module tb_top
  import dxbps_pkg::*;
;
  logic aclk, aresetn, cmd_valid, cmd_err, cmd_last, cmd_ready, rep_stb, irq;
  dxbps_kind_t cmd_kind;
  logic [6:0] cmd_src, cmd_dest, r_dest, rep_dest;
  logic [7:0] cmd_len, cmd_data, r_len, rep_len;
  logic [9:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int n_errors = 0;
  int n_tests = 0;
  int n_rep = 0;
  dxbps_link_if link();
  dxbps_dev_end u_dxbps_dev_end (.aclk(aclk), .aresetn(aresetn), .link(link),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));
  dxbps_bus_end u_dxbps_bus_end (.aclk(aclk), .aresetn(aresetn), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_src(cmd_src),
    .cmd_dest(cmd_dest), .cmd_len(cmd_len), .cmd_data(cmd_data), .cmd_err(cmd_err),
    .cmd_last(cmd_last), .rep_stb(rep_stb), .rep_dest(rep_dest), .rep_len(rep_len));
  dxbps_link_properties u_dxbps_link_properties (.aclk(aclk), .aresetn(aresetn),
    .tel_valid(link.tel_valid), .tel_ready(link.tel_ready), .tel_kind(link.tel_kind),
    .tel_len(link.tel_len), .tel_data(link.tel_data), .rsp_valid(link.rsp_valid),
    .rsp_ready(link.rsp_ready), .rsp_dest(link.rsp_dest));
  // ----------------------------------------------------------------------
  // Clock, reply monitor and bus tasks
  // ----------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Replies are single-cycle pulses, so they are counted as they pass
  always @(posedge aclk) begin
    if (rep_stb) begin
      n_rep <= n_rep + 1;
      r_dest <= rep_dest;
      r_len <= rep_len;
    end
  end
  task automatic complete_run();
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Address and data go out together; each is dropped once taken
  task automatic wr(input logic [9:0] a, input logic [31:0] dt, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [9:0] a, output logic [31:0] dt, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
    axr(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask
  task automatic send(input dxbps_kind_t k, input logic [6:0] s, input logic [7:0] l,
                      input logic [7:0] dt, input logic e);
    @(posedge aclk);
    cmd_kind <= k;
    cmd_src <= s;
    cmd_dest <= 7'h7f;
    cmd_len <= l;
    cmd_data <= dt;
    cmd_err <= e;
    cmd_last <= 1'b1;
    cmd_valid <= 1'b1;
    do @(posedge aclk); while (!cmd_ready);
    cmd_valid <= 1'b0;
    wt(3);
  endtask
  // Request from the master; reply count and interrupt line must agree
  task automatic fc7(input logic [7:0] l, input int exp);
    int n0;
    n0 = n_rep;
    send(DXBPS_TK_FC7, 7'h05, l, 8'h00, 1'b0);
    wt(3);
    chk(32'(n_rep - n0), 32'(exp));
    chk(32'(irq), 32'(exp));
  endtask
  // Poll until an interval expiry is flagged; the read also clears it
  task automatic wait_exp();
    do axr(10'h018, d, r); while (d[3] !== 1'b1);
  endtask
  // ----------------------------------------------------------------------
  // Test sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    {cmd_valid, cmd_err, cmd_last, awvalid, wvalid, bready, arvalid, rready} = '0;
    cmd_kind = DXBPS_TK_OTHER;
    wstrb = 4'hf;
    {cmd_src, cmd_dest, cmd_len, cmd_data, awaddr, araddr, wdata} = '0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(10'h008, 32'h0000c350, 2'b00);
    rd(10'h3fc, 32'h0, 2'b10);
    wr(10'h3fc, 32'h1, 2'b10);
    wr(10'h01c, 32'h4, 2'b00);
    wr(10'h014, 32'h10, 2'b00);
    fc7(8'h07, 0);
    wr(10'h000, 32'h1, 2'b00);
    fc7(8'h05, 0);
    fc7(8'h07, 1);
    chk(32'(r_dest), 32'h7f);
    chk(32'(r_len), 32'h10);
    // A write whose only lane misses the field must leave it alone
    wstrb <= 4'h2;
    wr(10'h014, 32'h000000ff, 2'b00);
    wstrb <= 4'hf;
    rd(10'h014, 32'h00000010, 2'b00);
    rd(10'h018, 32'h4, 2'b00);
    chk(32'(irq), 32'h0);
    send(DXBPS_TK_PRM, 7'h01, 8'h01, 8'ha5, 1'b0);
    rd(10'h020, 32'h1a5, 2'b00);
    axr(10'h020, d, r);
    chk(32'(d[8]), 32'h0);
    // Third entry lies beyond the table length and must stay unused
    wr(10'h100, 32'h03000411, 2'b00);
    wr(10'h104, 32'h02000622, 2'b00);
    wr(10'h108, 32'h02000433, 2'b00);
    wr(10'h00c, 32'h2, 2'b00);
    wr(10'h010, 32'h9, 2'b00);
    wr(10'h200, 32'h00008309, 2'b00);
    wr(10'h204, 32'h00220011, 2'b00);
    rd(10'h200, 32'h00008309, 2'b00);
    send(DXBPS_TK_BCAST, 7'h11, 8'h04, 8'h00, 1'b0);
    send(DXBPS_TK_BCAST, 7'h22, 8'h05, 8'h00, 1'b0);
    send(DXBPS_TK_BCAST, 7'h33, 8'h04, 8'h00, 1'b0);
    rd(10'h204, 32'h40220111, 2'b00);
    wr(10'h008, 32'd40, 2'b00);
    axr(10'h018, d, r);
    wr(10'h004, 32'h3, 2'b00);
    wait_exp();
    rd(10'h204, 32'h00228011, 2'b00);
    send(DXBPS_TK_BCAST, 7'h22, 8'h06, 8'h00, 1'b0);
    rd(10'h204, 32'h01228011, 2'b00);
    wait_exp();
    rd(10'h204, 32'h80220011, 2'b00);
    chk(32'(irq), 32'h0);
    send(DXBPS_TK_BCAST, 7'h11, 8'h04, 8'h00, 1'b1);
    rd(10'h204, 32'h80224011, 2'b00);
    complete_run();
  end
  // Whole sequence needs well under two thousand cycles
  initial begin
    wt(20000);
    n_errors++;
    complete_run();
  end
endmodule
